// [pkg/rgnam_defs.svh]
// Notes on behaviour
// (R1) Two independent region attribute registers
// (R2) Attributes from matching region, else defaults
// (R3) SRAM-mapped references skip region matching
// (R4) 32-bit, supervisor write only, not readable
// (R5) Written via control codes 0x004, 0x005
// (R6) Readable in background debug state
// (R7) Reset clears both registers to zero
// (R8) Base field compares address bits 31:24
// (R9) Mask bit one ignores that address bit
// (R10) Enable zero means region never matches
// (R11) Privilege filter: 00 user, 01 super, 1x any
// (R12) Cacheability bit: zero cacheable, one not
// (R13) Unbuffered write waits for external completion
// (R14) Buffered write terminates local bus immediately
// (R15) Write protect turns writes into access errors
// (R16) Write access errors reported imprecisely
// (R17) Default cacheability from cache control register
// (R18) Default buffered write from cache control
// (R19) Default write protect permits reads only
// (R20) First region wins when both match
`ifndef RGNAM_DEFS_SVH
`define RGNAM_DEFS_SVH
`define RGNAM_CODE_ZERO   12'h004
`define RGNAM_CODE_ONE    12'h005
`define RGNAM_RESET_VAL   32'h0000_0000
`define RGNAM_BASE_HI     31
`define RGNAM_BASE_LO     24
`define RGNAM_MASK_HI     23
`define RGNAM_MASK_LO     16
`define RGNAM_EN_BIT      15
`define RGNAM_PRIV_HI     14
`define RGNAM_PRIV_LO     13
`define RGNAM_NONCACHE_BIT 6
`define RGNAM_BUFWR_BIT    5
`define RGNAM_WP_BIT      2
`define RGNAM_WMASK       32'hffff_e064
`endif

// [pkg/rgnam_pkg.sv]
package rgnam_pkg;
    typedef logic [31:0] rgnam_word_t;
    typedef struct packed {
        logic noncache;
        logic buffered;
        logic wprot;
    } rgnam_attr_s;
    typedef enum logic [1:0] {
        RGNAM_IDLE,
        RGNAM_WAIT
    } rgnam_wstate_e;
endpackage

// [logic/rgnam_region_match.sv]
`timescale 1ns/100ps
`include "rgnam_defs.svh"
module rgnam_region_match
    import rgnam_pkg::*;
(
    // Region and reference
    input  wire rgnam_pkg::rgnam_word_t region_i,
    input  wire logic [7:0]             addr_hi_i,
    input  wire logic                   super_i,
    // Result
    output logic                        match_o
);
    import rgnam_pkg::*;
    logic [7:0] care;
    logic       priv_ok;
    assign care = ~region_i[`RGNAM_MASK_HI:`RGNAM_MASK_LO]; // R9
    always_comb begin
        case (region_i[`RGNAM_PRIV_HI:`RGNAM_PRIV_LO]) // R11
            2'h0:    priv_ok = ~super_i;
            2'h1:    priv_ok = super_i;
            default: priv_ok = 1'b1;
        endcase
    end
    assign match_o = region_i[`RGNAM_EN_BIT] & priv_ok // R10
        & (((addr_hi_i ^ region_i[`RGNAM_BASE_HI:`RGNAM_BASE_LO]) & care) == 8'h00); // R8
endmodule // rgnam_region_match

// [logic/rgnam_top.sv]
`timescale 1ns/100ps
`include "rgnam_defs.svh"
module rgnam_top
    import rgnam_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Control register write port
    input  wire logic        creg_wr_i,
    input  wire logic [11:0] control_register_code_i,
    input  wire logic [31:0] creg_wdata_i,
    input  wire logic        creg_super_i,
    // Debug read port
    input  wire logic        background_debug_state_i,
    input  wire logic        dbg_rd_i,
    input  wire logic [11:0] dbg_code_i,
    output logic [31:0]      dbg_rdata_o,
    output logic             dbg_rvalid_o,
    // Cache control defaults
    input  wire logic        default_cacheability_i,
    input  wire logic        default_buffered_write_i,
    input  wire logic        default_write_protect_i,
    // Local bus reference
    input  wire logic        ref_valid_i,
    input  wire logic [31:0] ref_addr_i,
    input  wire logic        ref_write_i,
    input  wire logic        ref_super_i,
    input  wire logic        ref_sram_hit_i,
    // Effective attributes
    output logic             attr_valid_o,
    output logic             attr_noncache_o,
    output logic             attr_buffered_o,
    output logic             attr_wprot_o,
    output logic             attr_region0_o,
    output logic             attr_region1_o,
    // Write termination
    input  wire logic        ext_done_i,
    output logic             wr_busy_o,
    output logic             wr_term_o,
    output logic             wr_buffer_o,
    output logic             access_err_o
);
    import rgnam_pkg::*;

    // ****************************************
    // Reset synchroniser
    // ****************************************
    // Async assert, clocked release so no flop leaves reset a cycle early
    logic [1:0] rst_sync_ff;
    logic       rst_n;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ****************************************
    // State
    // ****************************************
    // Both regions, debug read data and write tracking in one register
    typedef struct packed {
        rgnam_word_t [1:0] region;
        logic [31:0]       dbg_rdata;
        logic              dbg_rvalid;
        rgnam_wstate_e     wstate;
        logic              term;
        logic              buf_wr;
        logic              err;
    } rgnam_state_s;
    rgnam_state_s state_ff;
    rgnam_state_s nxt_state;

    // ****************************************
    // Region matching
    // ****************************************
    logic [1:0]  hit;
    rgnam_attr_s eff;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_region // R1
            rgnam_region_match u_match (
                .region_i  (state_ff.region[gi]),
                .addr_hi_i (ref_addr_i[31:24]),
                .super_i   (ref_super_i),
                .match_o   (hit[gi])
            );
        end
    endgenerate

    function automatic rgnam_attr_s region_attr(input rgnam_word_t r);
        region_attr.noncache = r[`RGNAM_NONCACHE_BIT]; // R12
        region_attr.buffered = r[`RGNAM_BUFWR_BIT];
        region_attr.wprot    = r[`RGNAM_WP_BIT];
    endfunction

    logic use0;
    logic use1;
    assign use0 = hit[0] & ~ref_sram_hit_i; // R3
    // Region zero wins an overlap, so region one only fills gaps
    assign use1 = hit[1] & ~hit[0] & ~ref_sram_hit_i; // R20
    always_comb begin
        if (use0) begin // R2
            eff = region_attr(state_ff.region[0]);
        end else if (use1) begin
            eff = region_attr(state_ff.region[1]);
        end else begin
            eff.noncache = default_cacheability_i; // R17
            eff.buffered = default_buffered_write_i; // R18
            eff.wprot    = default_write_protect_i; // R19
        end
    end

    // ****************************************
    // Attribute outputs
    // ****************************************
    // Valid follows the reference; attributes are purely combinational
    assign attr_valid_o    = ref_valid_i;
    assign attr_noncache_o = eff.noncache;
    assign attr_buffered_o = eff.buffered;
    assign attr_wprot_o    = eff.wprot;
    assign attr_region0_o  = ref_valid_i & use0;
    assign attr_region1_o  = ref_valid_i & use1;

    // ****************************************
    // Control register code decode
    // ****************************************
    // One-hot region select; any other code selects nothing
    function automatic logic [1:0] code_sel(input logic [11:0] code);
        case (code)
            `RGNAM_CODE_ZERO: code_sel = 2'h1;
            `RGNAM_CODE_ONE:  code_sel = 2'h2;
            default:          code_sel = 2'h0;
        endcase
    endfunction

    logic [1:0] wr_sel;
    logic [1:0] rd_sel;
    assign wr_sel = code_sel(control_register_code_i); // R5
    assign rd_sel = code_sel(dbg_code_i);

    // ****************************************
    // Next state
    // ****************************************
    logic wr_go;
    assign wr_go = ref_valid_i & ref_write_i;
    always_comb begin
        nxt_state = state_ff;
        nxt_state.term       = 1'b0;
        nxt_state.buf_wr     = 1'b0;
        nxt_state.err        = 1'b0;
        nxt_state.dbg_rvalid = 1'b0;
        // Writes only from supervisor; unused bits are stored as zero
        if (creg_wr_i && creg_super_i) begin // R4
            for (int i = 0; i < 2; i++) begin
                if (wr_sel[i]) begin // R5
                    nxt_state.region[i] = creg_wdata_i & `RGNAM_WMASK;
                end
            end
        end
        // Reads exist only through the debug port, software sees nothing
        if (dbg_rd_i && background_debug_state_i) begin // R6
            nxt_state.dbg_rvalid = 1'b1;
            nxt_state.dbg_rdata  = 32'h0000_0000;
            for (int i = 0; i < 2; i++) begin
                if (rd_sel[i]) begin
                    nxt_state.dbg_rdata = state_ff.region[i];
                end
            end
        end
        // Write termination; a single write is outstanding at a time
        case (state_ff.wstate)
            RGNAM_IDLE: begin
                if (wr_go) begin
                    if (eff.wprot) begin
                        // Error flagged a cycle later, not tied to the write
                        nxt_state.err  = 1'b1; // R15 R16
                        nxt_state.term = 1'b1;
                    end else if (eff.buffered) begin
                        nxt_state.term   = 1'b1; // R14
                        nxt_state.buf_wr = 1'b1;
                    end else if (ext_done_i) begin
                        nxt_state.term = 1'b1; // R13
                    end else begin
                        nxt_state.wstate = RGNAM_WAIT;
                    end
                end
            end
            RGNAM_WAIT: begin
                if (ext_done_i) begin // R13
                    nxt_state.term   = 1'b1;
                    nxt_state.wstate = RGNAM_IDLE;
                end
            end
            default: nxt_state.wstate = RGNAM_IDLE;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '0; // R7
            state_ff.wstate <= RGNAM_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    assign dbg_rdata_o  = state_ff.dbg_rdata;
    assign dbg_rvalid_o = state_ff.dbg_rvalid;
    assign wr_busy_o    = (state_ff.wstate == RGNAM_WAIT);
    assign wr_term_o    = state_ff.term;
    assign wr_buffer_o  = state_ff.buf_wr;
    assign access_err_o = state_ff.err;
endmodule // rgnam_top

// [tb/rgnam_asserts.sv]
`timescale 1ns/100ps
module rgnam_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Debug read port
    input wire logic dbg_rd_i,
    input wire logic background_debug_state_i,
    input wire logic dbg_rvalid_o,
    // Cache control defaults
    input wire logic default_cacheability_i,
    input wire logic default_buffered_write_i,
    input wire logic default_write_protect_i,
    // Local bus reference
    input wire logic ref_valid_i,
    input wire logic ref_write_i,
    input wire logic ref_sram_hit_i,
    // Effective attributes
    input wire logic attr_noncache_o,
    input wire logic attr_buffered_o,
    input wire logic attr_wprot_o,
    input wire logic attr_region0_o,
    input wire logic attr_region1_o,
    // Write termination
    input wire logic ext_done_i,
    input wire logic wr_busy_o,
    input wire logic wr_term_o,
    input wire logic wr_buffer_o,
    input wire logic access_err_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic go = ref_valid_i && ref_write_i && !wr_busy_o;
    wire logic none = !attr_region0_o && !attr_region1_o;
    wp_err_a: assert property (go && attr_wprot_o |=> access_err_o && wr_term_o)
        else $error("no access error");
    rd_ok_a: assert property (ref_valid_i && !ref_write_i && !wr_busy_o |=> !access_err_o)
        else $error("read refused");
    buf_term_a: assert property (go && !attr_wprot_o && attr_buffered_o
        |=> wr_term_o && wr_buffer_o)
        else $error("no buffered end");
    unbuf_wait_a: assert property (go && !attr_wprot_o && !attr_buffered_o && !ext_done_i
        |=> wr_busy_o && !wr_term_o)
        else $error("no wait");
    busy_hold_a: assert property (wr_busy_o && !ext_done_i |=> wr_busy_o)
        else $error("busy dropped");
    done_term_a: assert property (wr_busy_o && ext_done_i |=> wr_term_o && !wr_busy_o)
        else $error("no end");
    sram_skip_a: assert property (ref_valid_i && ref_sram_hit_i |-> none)
        else $error("sram matched");
    dflt_attr_a: assert property (ref_valid_i && none |->
        {attr_noncache_o, attr_buffered_o, attr_wprot_o}
        == {default_cacheability_i, default_buffered_write_i, default_write_protect_i})
        else $error("bad defaults");
    one_region_a: assert property (ref_valid_i |-> !(attr_region0_o && attr_region1_o))
        else $error("two regions");
    dbg_rd_a: assert property (dbg_rvalid_o == $past(dbg_rd_i && background_debug_state_i))
        else $error("bad rvalid");
endmodule // rgnam_asserts
bind rgnam_top rgnam_asserts rgnam_asserts_i (
    .clk_i                    (clk_i),
    .reset_n_i                (reset_n_i),
    .dbg_rd_i                 (dbg_rd_i),
    .background_debug_state_i (background_debug_state_i),
    .dbg_rvalid_o             (dbg_rvalid_o),
    .default_cacheability_i   (default_cacheability_i),
    .default_buffered_write_i (default_buffered_write_i),
    .default_write_protect_i  (default_write_protect_i),
    .ref_valid_i              (ref_valid_i),
    .ref_write_i              (ref_write_i),
    .ref_sram_hit_i           (ref_sram_hit_i),
    .attr_noncache_o          (attr_noncache_o),
    .attr_buffered_o          (attr_buffered_o),
    .attr_wprot_o             (attr_wprot_o),
    .attr_region0_o           (attr_region0_o),
    .attr_region1_o           (attr_region1_o),
    .ext_done_i               (ext_done_i),
    .wr_busy_o                (wr_busy_o),
    .wr_term_o                (wr_term_o),
    .wr_buffer_o              (wr_buffer_o),
    .access_err_o             (access_err_o)
);

// [tb/rgnam_ext_bus.sv]
`timescale 1ns/100ps
module rgnam_ext_bus (
    input  wire logic       clk_i,
    input  wire logic       busy_i,
    input  wire logic [2:0] lat_i,
    output logic            done_o
);
    logic [2:0] cnt = 3'h0;
    initial done_o = 1'b0;
    // Latency set by the bench, zero gives the fastest answer
    always @(posedge clk_i) begin
        cnt <= busy_i ? cnt + 3'h1 : 3'h0;
        done_o <= #1 busy_i && cnt == lat_i && !done_o;
    end
endmodule // rgnam_ext_bus

// [tb/tb_top.sv]
`timescale 1ns/100ps
`include "rgnam_defs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: %h %h", $time, a, b); end end
module tb_top;
    logic clk_i = 0, reset_n_i = 0, wr = 0, sup = 0, dst = 1, rd = 0, dc = 0, db = 0, dw = 0;
    logic rv = 0, rw = 0, rs = 0, rsr = 0;
    logic [11:0] code = 0, dcode = 0;
    logic [31:0] wd = 0, ra = 0, r0 = 0, r1 = 0;
    logic [2:0] lat = 0;
    wire logic [31:0] dat;
    wire logic ext, dvld, av, nc, bf, wp, g0, g1, busy, term, buff, err;
    int num_errors = 0, compares = 0, cyc = 0;
    rgnam_top rgnam_top_i (.clk_i, .reset_n_i, .creg_wr_i(wr), .control_register_code_i(code),
        .creg_wdata_i(wd), .creg_super_i(sup), .background_debug_state_i(dst), .dbg_rd_i(rd),
        .dbg_code_i(dcode), .dbg_rdata_o(dat), .dbg_rvalid_o(dvld), .default_cacheability_i(dc),
        .default_buffered_write_i(db), .default_write_protect_i(dw), .ref_valid_i(rv),
        .ref_addr_i(ra), .ref_write_i(rw), .ref_super_i(rs), .ref_sram_hit_i(rsr),
        .attr_valid_o(av), .attr_noncache_o(nc), .attr_buffered_o(bf), .attr_wprot_o(wp),
        .attr_region0_o(g0), .attr_region1_o(g1), .ext_done_i(ext), .wr_busy_o(busy),
        .wr_term_o(term), .wr_buffer_o(buff), .access_err_o(err));
    rgnam_ext_bus rgnam_ext_bus_i (.clk_i, .busy_i(busy), .lat_i(lat), .done_o(ext));
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test;
        end
    end
    task automatic stop_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic hit(logic [31:0] r);
        return r[15] && (r[14] || r[13] == rs)
            && !(~r[23:16] & (r[31:24] ^ ra[31:24]));
    endfunction
    task automatic cwr(logic [11:0] c, logic [31:0] d, logic s);
        @(posedge clk_i) #1 code = c;
        wd = d;
        sup = s;
        wr = 1;
        @(posedge clk_i) #1 wr = 0;
        if (s && c == 12'h004) r0 = d & `RGNAM_WMASK;
        if (s && c == 12'h005) r1 = d & `RGNAM_WMASK;
    endtask
    task automatic drd(logic [11:0] c, logic [31:0] e, logic v);
        @(posedge clk_i) #1 dcode = c;
        dst = v;
        rd = 1;
        @(posedge clk_i) #1 rd = 0;
        `CHK(dvld, v)
        if (v) `CHK(dat, e)
    endtask
    task automatic ref_go(logic [31:0] a, logic w, logic s, logic sr);
        logic m0, m1;
        logic [1:0] e;
        int n;
        @(posedge clk_i) #1 ra = a;
        rw = w;
        rs = s;
        rsr = sr;
        rv = 1;
        m0 = !sr && hit(r0);
        m1 = !sr && !m0 && hit(r1);
        e = m0 ? {r0[5], r0[2]} : m1 ? {r1[5], r1[2]} : {db, dw};
        #1 `CHK({g0, g1, nc, bf, wp}, {m0, m1, m0 ? r0[6] : m1 ? r1[6] : dc, e})
        `CHK(av, 1'b1)
        @(posedge clk_i) #1 rv = 0;
        for (n = 0; n < 20 && w && !term; n++) @(posedge clk_i) #1;
        if (w) `CHK({term, err, buff}, {1'b1, e[0], e == 2'b10})
        if (w) `CHK(n == 0, e != 2'b00)
        if (!w) `CHK(err, 1'b0)
    endtask
    initial begin
        void'($urandom(32'hc6bb7dd8));
        repeat (2) @(posedge clk_i);
        #1 reset_n_i = 1;
        repeat (3) @(posedge clk_i);
        drd(12'h004, 0, 1);
        drd(12'h005, 0, 1);
        cwr(12'h004, 32'hffff_ffff, 0);
        cwr(12'h006, 32'hffff_ffff, 1);
        drd(12'h004, 0, 1);
        drd(12'h006, 0, 1);
        drd(12'h005, 0, 1);
        cwr(12'h004, 32'h1200_c044, 1);
        cwr(12'h005, 32'h1200_c020, 1);
        ref_go(32'h1234_5678, 1, 0, 0);
        ref_go(32'h1234_5678, 1, 1, 1);
        drd(12'h004, r0, 0);
        repeat (150) begin
            {dc, db, dw} = 3'($urandom);
            lat = 3'($urandom);
            cwr(12'h004 + 12'($urandom % 2), $urandom, 1'($urandom));
            drd(12'h004, r0, 1);
            drd(12'h005, r1, 1);
            repeat (3) ref_go({(1'($urandom) ? r0[31:24] : r1[31:24]) ^ 8'($urandom % 4),
                24'($urandom)}, 1'($urandom), 1'($urandom), $urandom % 5 == 0);
        end
        // Reset in mid-run must clear both regions again
        @(posedge clk_i) #1 reset_n_i = 0;
        r0 = 0;
        r1 = 0;
        repeat (2) @(posedge clk_i);
        #1 reset_n_i = 1;
        repeat (3) @(posedge clk_i);
        drd(12'h004, r0, 1);
        drd(12'h005, r1, 1);
        stop_test;
    end
endmodule // tb_top
